/* File: verilog/flash_otp_pkg.sv */
package flash_otp_pkg;

  // ****************************************************************
  // Command codes
  // ****************************************************************
  localparam logic [7:0] OP_OTP_READ = 8'h4b;
  localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
  localparam logic [7:0] OP_DUAL_WRITE = 8'ha2;
  localparam logic [7:0] OP_OTP_WRITE = 8'h42;
  localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;

  // ****************************************************************
  // Frame layout, counted in serial clocks
  // ****************************************************************
  localparam logic [5:0] OPCODE_CLKS = 6'h08;
  localparam logic [5:0] OP_LAST_CLK = 6'h07;
  localparam logic [5:0] ADDR_LAST_CLK = 6'h1f;
  localparam logic [5:0] HDR_CLKS = 6'h20;
  localparam logic [5:0] DUMMY_LAST_CLK = 6'h27;
  localparam logic [5:0] RD_DATA_CLKS = 6'h28;

  // ****************************************************************
  // Array geometry and values
  // ****************************************************************
  localparam int PAGE_BYTES = 256;
  localparam int OTP_BYTES = 65;
  localparam logic [7:0] PAGE_LAST = 8'hff;
  localparam logic [7:0] OTP_LAST = 8'h40;
  localparam logic [6:0] OTP_CTRL_IDX = 7'h40;
  localparam int OTP_LOCK_BIT = 0;
  localparam logic [7:0] ERASED = 8'hff;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int PAGE_WRITE_TIME_US_DFLT = 800;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_MERGE = 3'b010,
    ST_WAIT = 3'b100
  } cycle_state_t;

endpackage

/* File: verilog/level_sync.sv */
`timescale 1ns/1ns
module level_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Level in and out
  input wire logic d,
  output logic q
);
  logic s1, s2, s3;

  // Three stages; output follows once the last two agree
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s1 <= RESET_VAL;
      s2 <= RESET_VAL;
      s3 <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) q <= s3;
    end
  end
endmodule

/* File: verilog/flash_cell_array.sv */
`timescale 1ns/1ns
module flash_cell_array import flash_otp_pkg::*; #(
  parameter int WORDS = 256,
  parameter int AW = 8
) (
  // Write port
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  // Read ports
  input wire logic [AW-1:0] a_addr,
  output logic [7:0] a_data,
  input wire logic [AW-1:0] b_addr,
  output logic [7:0] b_data
);
  // Arrays leave the factory erased; the write process is the only writer
  logic [7:0] cells [WORDS] = '{default: ERASED};

  if (WORDS > (1 << AW) || WORDS < 1) begin : g_bad_size
    $error("flash_cell_array: WORDS does not fit AW");
  end

  // Programming only pulls bits low
  always_ff @(posedge clk) begin
    if (we) cells[waddr] <= cells[waddr] & wdata;
  end

  assign a_data = cells[a_addr];
  assign b_data = cells[b_addr];
endmodule

/* File: verilog/serial_flash_program_otp.sv */
`timescale 1ns/1ns
module serial_flash_program_otp import flash_otp_pkg::*; #(
  parameter int PAGES = 16,
  parameter int PAGE_WRITE_TIME_US = PAGE_WRITE_TIME_US_DFLT,
  localparam int PAGE_AW = $clog2(PAGES)
) (
  // System
  input wire logic mclk,
  input wire logic reset_n,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic data_line_0_in,
  input wire logic data_line_1_in,
  output logic data_line_1_out,
  output logic data_line_1_oe,
  // Protect field
  input wire logic protect_field_bit0,
  input wire logic protect_field_bit1,
  input wire logic protect_field_bit2,
  // Status
  output logic cycle_active_flag,
  output logic write_unlock_latch,
  // Array inspection
  input wire logic [PAGE_AW+7:0] peek_addr,
  output logic [7:0] peek_data
);
  localparam int PROG_CYCLES_RAW = PAGE_WRITE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int PROG_CYCLES = (PROG_CYCLES_RAW < 1) ? 1 : PROG_CYCLES_RAW;
  localparam int TW = $clog2(PROG_CYCLES + 1);

  if (PAGES < 2 || (PAGES & (PAGES - 1)) != 0) begin : g_bad_pages
    $error("serial_flash_program_otp: PAGES must be a power of two, at least 2");
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [6:0] otp_clamp(input logic [6:0] a);
    return (a > OTP_CTRL_IDX) ? OTP_CTRL_IDX : a;
  endfunction

  // Upper pages guarded; field 7 guards all
  function automatic logic is_protected(input logic [2:0] bp, input logic [PAGE_AW-1:0] pg);
    int span;
    span = PAGES >> (7 - int'(bp));
    return (bp != 3'h0) && (int'(pg) >= PAGES - span);
  endfunction

  // ****************************************************************
  // Link side, clocked by the serial clock
  // ****************************************************************
  logic started, frame_tgl, rd_ok, clr_pend, busy_link;
  logic [5:0] hdr_cnt;
  logic [31:0] cmd_sr;
  logic [7:0] op, wptr, byte_sr;
  logic [2:0] part, rd_bit;
  logic [8:0] nbytes;
  logic [255:0] mask;
  logic [7:0] page_buf [PAGE_BYTES];
  logic [6:0] rd_ptr;
  logic [7:0] otp_a_data, otp_b_data;

  wire link_clr = cs_n | ~reset_n;
  wire first = ~started;
  wire [5:0] cnt = first ? 6'h00 : hdr_cnt;
  wire op_dual = (op == OP_DUAL_WRITE);
  wire op_otp_w = (op == OP_OTP_WRITE);
  wire op_prog = (op == OP_PAGE_WRITE) | op_dual | op_otp_w;
  wire prog_phase = (cnt >= HDR_CLKS) & op_prog;
  wire rd_phase = ~first & (hdr_cnt == RD_DATA_CLKS);
  wire [3:0] part_sum = {1'b0, part} + (op_dual ? 4'h2 : 4'h1);
  // Dual pair: line 1 upper bit, line 0 lower bit
  wire [7:0] byte_next = op_dual ? {byte_sr[5:0], data_line_1_in, data_line_0_in}
                                 : {byte_sr[6:0], data_line_0_in};
  wire byte_done = prog_phase & part_sum[3];
  // OTP bytes past the control byte are dropped
  wire store = byte_done & ~busy_link & (~op_otp_w | (wptr <= OTP_LAST));
  wire [7:0] addr_lo = {cmd_sr[6:0], data_line_0_in};
  wire [7:0] wptr_load = op_otp_w ? {1'b0, addr_lo[6:0]} : addr_lo;
  wire [7:0] wptr_inc = wptr + 8'h01;
  wire [255:0] onehot = {{255{1'b0}}, 1'b1} << wptr;

  // Frame start marker, cleared whenever chip select is high
  always_ff @(posedge sclk or posedge link_clr) begin
    if (link_clr) started <= 1'b0;
    else started <= 1'b1;
  end

  // Header shift, byte assembly and read pointer
  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      frame_tgl <= 1'b0;
      hdr_cnt <= 6'h00;
      cmd_sr <= 32'h0000_0000;
      op <= 8'h00;
      wptr <= 8'h00;
      byte_sr <= 8'h00;
      part <= 3'h0;
      nbytes <= 9'h000;
      clr_pend <= 1'b1;
      mask <= '0;
      rd_ok <= 1'b0;
      rd_ptr <= 7'h00;
      rd_bit <= 3'h0;
    end else begin
      if (first) begin
        frame_tgl <= ~frame_tgl;
        clr_pend <= 1'b1;
        rd_ok <= 1'b0;
        nbytes <= 9'h000;
        part <= 3'h0;
      end
      if (cnt < RD_DATA_CLKS) hdr_cnt <= cnt + 6'h01;
      if (cnt < HDR_CLKS) cmd_sr <= {cmd_sr[30:0], data_line_0_in};
      if (cnt == OP_LAST_CLK) op <= addr_lo;
      if (cnt == ADDR_LAST_CLK) wptr <= wptr_load;
      if (prog_phase) begin
        byte_sr <= byte_next;
        part <= part_sum[2:0];
      end
      if (byte_done && nbytes != 9'h1ff) nbytes <= nbytes + 9'h001;
      // Later bytes overwrite earlier ones at the same wrapped slot
      if (store) begin
        mask <= (clr_pend ? '0 : mask) | onehot;
        clr_pend <= 1'b0;
        wptr <= wptr_inc;
      end
      if (cnt == DUMMY_LAST_CLK) begin
        rd_ok <= (op == OP_OTP_READ) & ~busy_link;
        rd_ptr <= otp_clamp(cmd_sr[6:0]);
        rd_bit <= 3'h0;
      end
      if (rd_phase) begin
        rd_bit <= rd_bit + 3'h1;
        if (rd_bit == 3'h7) rd_ptr <= otp_clamp(rd_ptr + 7'h01);
      end
    end
  end

  // Page buffer, written only while no cycle reads it
  always_ff @(posedge sclk) begin
    if (store) page_buf[wptr] <= byte_next;
  end

  // Read data out on the falling edge, released with chip select
  always_ff @(negedge sclk or posedge link_clr) begin
    if (link_clr) begin
      data_line_1_out <= 1'b0;
      data_line_1_oe <= 1'b0;
    end else begin
      data_line_1_out <= otp_a_data[~rd_bit];
      data_line_1_oe <= rd_ok & rd_phase;
    end
  end

  level_sync #(.RESET_VAL(1'b0)) u_busy_sync (
    .clk(sclk),
    .reset_n(reset_n),
    .d(cycle_active_flag),
    .q(busy_link)
  );

  // ****************************************************************
  // Core side, clocked by mclk
  // ****************************************************************
  logic cs_s, tgl_s, cs_q, seen_tgl, kind_otp;
  cycle_state_t state, next_state;
  logic [7:0] idx;
  logic [TW-1:0] timer;
  logic [PAGE_AW-1:0] page_q;
  logic [7:0] main_peek;

  level_sync #(.RESET_VAL(1'b1)) u_cs_sync (
    .clk(mclk),
    .reset_n(reset_n),
    .d(cs_n),
    .q(cs_s)
  );

  level_sync #(.RESET_VAL(1'b0)) u_tgl_sync (
    .clk(mclk),
    .reset_n(reset_n),
    .d(frame_tgl),
    .q(tgl_s)
  );

  // Link words are stable here: the serial clock is idle once select is high
  wire cs_rise = cs_s & ~cs_q;
  wire frame_new = cs_rise & (tgl_s != seen_tgl);
  wire m_page_op = (op == OP_PAGE_WRITE) | op_dual;
  wire write_unlock_cmd_ok = (op == OP_WRITE_UNLOCK) & (hdr_cnt == OPCODE_CLKS);
  wire framed = (hdr_cnt >= HDR_CLKS) & (nbytes != 9'h000) & (part == 3'h0);
  wire [PAGE_AW-1:0] page_sel = cmd_sr[8 +: PAGE_AW];
  wire [2:0] bp = {protect_field_bit2, protect_field_bit1, protect_field_bit0};
  wire prot = is_protected(bp, page_sel);
  wire lock_open = otp_b_data[OTP_LOCK_BIT];
  wire idle = (state == ST_IDLE);
  wire start_page = frame_new & m_page_op & framed & write_unlock_latch & idle & ~prot;
  wire start_otp = frame_new & op_otp_w & framed & write_unlock_latch & idle & lock_open;
  wire start_any = start_page | start_otp;
  wire merge_last = (idx == (kind_otp ? OTP_LAST : PAGE_LAST));
  wire timer_end = (timer >= TW'(PROG_CYCLES - 1));
  wire merging = (state == ST_MERGE);
  wire mask_rd = mask[idx];
  wire [7:0] buf_rd = page_buf[idx];
  wire main_we = merging & ~kind_otp & mask_rd;
  wire otp_we = merging & kind_otp & mask_rd;

  // Cycle sequencing
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_any) next_state = ST_MERGE;
      end
      ST_MERGE: begin
        if (merge_last) next_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (timer_end) next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Cycle state, timer and status flags
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      cs_q <= 1'b1;
      seen_tgl <= 1'b0;
      cycle_active_flag <= 1'b0;
      write_unlock_latch <= 1'b0;
      timer <= '0;
      idx <= 8'h00;
      kind_otp <= 1'b0;
      page_q <= '0;
      peek_data <= 8'h00;
    end else begin
      state <= next_state;
      cs_q <= cs_s;
      if (cs_rise) seen_tgl <= tgl_s;
      cycle_active_flag <= (next_state != ST_IDLE);
      timer <= start_any ? '0 : (timer_end ? timer : timer + TW'(1));
      idx <= merging ? idx + 8'h01 : 8'h00;
      if (start_any) begin
        kind_otp <= start_otp;
        page_q <= page_sel;
      end
      if (start_any) write_unlock_latch <= 1'b0;
      else if (frame_new && write_unlock_cmd_ok) write_unlock_latch <= 1'b1;
      peek_data <= main_peek;
    end
  end

  flash_cell_array #(.WORDS(PAGES * PAGE_BYTES), .AW(PAGE_AW + 8)) u_main (
    .clk(mclk),
    .we(main_we),
    .waddr({page_q, idx}),
    .wdata(buf_rd),
    .a_addr(peek_addr),
    .a_data(main_peek),
    .b_addr('0),
    .b_data()
  );

  flash_cell_array #(.WORDS(OTP_BYTES), .AW(7)) u_otp (
    .clk(mclk),
    .we(otp_we),
    .waddr(idx[6:0]),
    .wdata(buf_rd),
    .a_addr(rd_ptr),
    .a_data(otp_a_data),
    .b_addr(OTP_CTRL_IDX),
    .b_data(otp_b_data)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Two clock domains here, so every check names its own clock
  sequence s_busy_run;
    (cycle_active_flag && !write_unlock_latch) [*2];
  endsequence

  chk_start_busy: assert property (@(posedge mclk) disable iff (!reset_n)
    start_any |=> s_busy_run)
    else $error("cycle start did not raise busy and drop latch");
  chk_need_unlock: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(cycle_active_flag) |-> $past(write_unlock_latch))
    else $error("cycle started without unlock latch");
  chk_protect_block: assert property (@(posedge mclk) disable iff (!reset_n)
    frame_new && m_page_op && prot |=> !$rose(cycle_active_flag))
    else $error("protected page programmed");
  chk_otp_locked: assert property (@(posedge mclk) disable iff (!reset_n)
    frame_new && op_otp_w && !lock_open |=> !$rose(cycle_active_flag))
    else $error("locked OTP programmed");
  chk_busy_reject: assert property (@(posedge mclk) disable iff (!reset_n)
    state == ST_WAIT && !timer_end && frame_new |=> state == ST_WAIT)
    else $error("running cycle disturbed by new frame");
  chk_abandon_frame: assert property (@(posedge mclk) disable iff (!reset_n)
    frame_new && op_prog && part != 3'h0 |=> !$rose(cycle_active_flag))
    else $error("misaligned frame started a cycle");
  chk_cycle_len: assert property (@(posedge mclk) disable iff (!reset_n)
    $fell(cycle_active_flag) |-> $past(timer) >= TW'(PROG_CYCLES - 1))
    else $error("cycle ended before program time");
  chk_cs_quiet: assert property (@(posedge mclk) disable iff (!reset_n)
    cs_s |-> !data_line_1_oe)
    else $error("line 1 driven with chip select high");
  chk_rd_cap: assert property (@(posedge sclk) disable iff (!reset_n)
    rd_ok |-> rd_ptr <= OTP_CTRL_IDX)
    else $error("OTP read pointer past last byte");
  chk_rd_hold: assert property (@(posedge sclk) disable iff (!reset_n)
    rd_phase && rd_ptr == OTP_CTRL_IDX |=> rd_ptr == OTP_CTRL_IDX)
    else $error("OTP read rolled over");
  chk_otp_store: assert property (@(posedge sclk) disable iff (!reset_n)
    store && op_otp_w |-> wptr <= OTP_LAST)
    else $error("OTP byte latched past control byte");
  chk_oe_phase: assert property (@(posedge sclk) disable iff (!reset_n)
    data_line_1_oe |-> rd_ok && hdr_cnt == RD_DATA_CLKS)
    else $error("line 1 driven outside OTP read data");
endmodule

/* File: sim/spi_host_model.sv */
`timescale 1ns/1ns
// ****************************************************************
// Host side of the serial link, mode 0, clock idles low
// ****************************************************************
module spi_host_model (
  // Serial link driven by the host
  output logic sclk,
  output logic cs_n,
  output logic data_line_0_in,
  output logic data_line_1_in,
  // Device answer
  input wire logic data_line_1_out,
  input wire logic data_line_1_oe
);
  logic oe_seen;
  logic oe_after_end;

  // Idle link at time zero
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    data_line_0_in = 1'b1;
    data_line_1_in = 1'b0;
    oe_seen = 1'b0;
    oe_after_end = 1'b0;
  end

  // One clock, data set while the clock is low
  task automatic clock_pair(input logic d1, input logic d0);
    data_line_1_in = d1;
    data_line_0_in = d0;
    #6 sclk = 1'b1;
    #6 sclk = 1'b0;
  endtask

  // Select the device
  task automatic frame_begin();
    oe_seen = 1'b0;
    cs_n = 1'b0;
    #6;
  endtask

  // Top n bits of a byte on line 0, MSB first; line 1 keeps toggling
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      clock_pair(~data_line_1_in, b[i]);
    end
  endtask

  // One byte as four bit pairs, upper bit on line 1
  task automatic send_dual(input logic [7:0] b);
    for (int i = 3; i >= 0; i--) begin
      clock_pair(b[2*i+1], b[2*i]);
    end
  endtask

  // One byte from line 1, sampled on the rising edge
  task automatic recv_byte(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      data_line_0_in = ~data_line_0_in;
      #6 sclk = 1'b1;
      // An undriven line shows the inverse of what the device left on it
      b[i] = data_line_1_oe ? data_line_1_out : ~data_line_1_out;
      oe_seen = oe_seen | data_line_1_oe;
      #6 sclk = 1'b0;
    end
  endtask

  // Deselect after the last clock, whole byte or not, then leave the gap between frames
  task automatic frame_end();
    #6 cs_n = 1'b1;
    #1 oe_after_end = data_line_1_oe;
    data_line_0_in = ~data_line_0_in;
    data_line_1_in = ~data_line_1_in;
    #393;
  endtask
endmodule

/* File: sim/tb_serial_flash_program_otp.sv */
`timescale 1ns/1ns
// ****************************************************************
// Bench for the program and OTP sequencer
// ****************************************************************
module tb_serial_flash_program_otp import flash_otp_pkg::*; ;
  logic mclk, reset_n, sclk, cs_n, data_line_0_in, data_line_1_in;
  logic data_line_1_out, data_line_1_oe, cycle_active_flag, write_unlock_latch;
  logic protect_field_bit0, protect_field_bit1, protect_field_bit2;
  logic [9:0] peek_addr;
  logic [7:0] peek_data;
  logic [7:0] q[$];
  logic [7:0] rd;
  int num_errors, n_tests, cycles;

  serial_flash_program_otp #(.PAGES(4), .PAGE_WRITE_TIME_US(20)) dut (.mclk, .reset_n, .sclk,
    .cs_n, .data_line_0_in, .data_line_1_in, .data_line_1_out, .data_line_1_oe,
    .protect_field_bit0, .protect_field_bit1, .protect_field_bit2, .cycle_active_flag,
    .write_unlock_latch, .peek_addr, .peek_data);
  spi_host_model host (.sclk, .cs_n, .data_line_0_in, .data_line_1_in, .data_line_1_out,
    .data_line_1_oe);

  // Core clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Opcode and three address bytes
  task automatic hdr(input logic [7:0] op, input logic [23:0] addr);
    host.frame_begin();
    host.send_bits(op, 8);
    for (int i = 2; i >= 0; i--) host.send_bits(addr[8*i +: 8], 8);
  endtask

  task automatic unlock();
    host.frame_begin();
    host.send_bits(OP_WRITE_UNLOCK, 8);
    host.frame_end();
    check("unlock latch", 8'h01, {7'h00, write_unlock_latch});
  endtask

  // Program frame from q, with optional stray bits before deselect
  task automatic frame(input logic [7:0] op, input logic [23:0] addr, input bit dual,
                       input int stray);
    hdr(op, addr);
    foreach (q[i]) begin
      if (dual) host.send_dual(q[i]);
      else host.send_bits(q[i], 8);
    end
    host.send_bits(8'h00, stray);
    host.frame_end();
  endtask

  // Flags after a frame, then wait out an accepted cycle
  task automatic settle(input string what, input logic busy, input logic latch);
    @(negedge mclk);
    check({what, " busy"}, {7'h00, busy}, {7'h00, cycle_active_flag});
    check({what, " latch"}, {7'h00, latch}, {7'h00, write_unlock_latch});
    for (int i = 0; i < 1000 && cycle_active_flag !== 1'b0; i++) @(negedge mclk);
    check({what, " done"}, 8'h00, {7'h00, cycle_active_flag});
  endtask

  task automatic peek(input logic [9:0] a, input logic [7:0] exp);
    @(posedge mclk) peek_addr <= a;
    repeat (2) @(negedge mclk);
    check($sformatf("byte %h", a), exp, peek_data);
  endtask

  task automatic otp_read(input logic [23:0] addr, input int n);
    q = {};
    hdr(OP_OTP_READ, addr);
    host.send_bits(8'h00, 8);
    repeat (n) begin
      host.recv_byte(rd);
      q.push_back(rd);
    end
    host.frame_end();
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    reset_n = 1'b0;
    {protect_field_bit2, protect_field_bit1, protect_field_bit0} = 3'h0;
    peek_addr = 10'h000;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (6) @(posedge mclk);
    // Program without unlock is ignored
    q = '{8'h00};
    frame(OP_PAGE_WRITE, 24'h00_0000, 0, 0);
    settle("no unlock", 1'b0, 1'b0);
    peek(10'h000, ERASED);
    // Wrap past the page end, other bytes untouched
    unlock();
    q = '{8'h11, 8'h22, 8'h33, 8'h44};
    frame(OP_PAGE_WRITE, 24'hfc_01fe, 0, 0);
    settle("wrap", 1'b1, 1'b0);
    peek(10'h1fe, 8'h11);
    peek(10'h1ff, 8'h22);
    peek(10'h100, 8'h33);
    peek(10'h101, 8'h44);
    peek(10'h102, ERASED);
    // Ones stay, zeros stick
    unlock();
    q = '{8'hf0};
    frame(OP_PAGE_WRITE, 24'h00_01fe, 0, 0);
    settle("and", 1'b1, 1'b0);
    peek(10'h1fe, 8'h10);
    // Dual write of 258 bytes: first two discarded
    unlock();
    q = {};
    for (int i = 0; i < 258; i++) q.push_back(i < 256 ? 8'(i) : 8'(8'ha5 + i));
    frame(OP_DUAL_WRITE, 24'h00_0200, 1, 0);
    settle("dual", 1'b1, 1'b0);
    peek(10'h200, 8'ha5);
    peek(10'h201, 8'ha6);
    peek(10'h202, 8'h02);
    peek(10'h2fe, 8'hfe);
    // Deselect off a byte boundary, then a protected page
    unlock();
    q = '{8'h00};
    frame(OP_PAGE_WRITE, 24'h00_0300, 0, 3);
    settle("abort", 1'b0, 1'b1);
    @(posedge mclk) {protect_field_bit2, protect_field_bit1, protect_field_bit0} <= 3'h7;
    frame(OP_PAGE_WRITE, 24'h00_0300, 0, 0);
    settle("protect", 1'b0, 1'b1);
    peek(10'h300, ERASED);
    @(posedge mclk) {protect_field_bit2, protect_field_bit1, protect_field_bit0} <= 3'h0;
    // OTP write from index 62, fourth byte past the end
    q = '{8'ha1, 8'hb2, 8'h35, 8'h00};
    frame(OP_OTP_WRITE, 24'hff_ffbe, 0, 0);
    // Let the merge finish so the read lands in the timed wait
    repeat (70) @(posedge mclk);
    otp_read(24'h00_003e, 1);
    check("read while busy", 8'h00, {7'h00, host.oe_seen});
    settle("otp", 1'b1, 1'b0);
    otp_read(24'h7a_5fbe, 5);
    check("otp 62", 8'ha1, q[0]);
    check("otp 63", 8'hb2, q[1]);
    for (int i = 2; i < 5; i++) check("otp end", 8'h35, q[i]);
    check("line driven", 8'h01, {7'h00, host.oe_seen});
    check("line released", 8'h00, {7'h00, host.oe_after_end});
    // Lock the OTP area, then try again
    unlock();
    q = '{8'hfe};
    frame(OP_OTP_WRITE, 24'h00_0040, 0, 0);
    settle("lock", 1'b1, 1'b0);
    unlock();
    q = '{8'h00};
    frame(OP_OTP_WRITE, 24'h00_0000, 0, 0);
    settle("locked", 1'b0, 1'b1);
    otp_read(24'h00_0000, 1);
    check("otp 0", 8'hff, q[0]);
    tally_and_finish();
  end
endmodule
